// file: scpm_clock_power_ctrl.v
// System clock select and power mode controller with Avalon-MM registers
// Contract
// - Halt with idle_select 0 enters sleep: CPU and time base stop.
// - Halt, idle_select 1, clock keep 0: idle_clock_stopped_mode, system oscillator stops.
// - Halt, idle_select 1, clock keep 1: idle_clock_running_mode, only CPU stops.
// - Sleep holds CPU stopped with no system clock; low clock runs.
// - Voltage detect enabled at halt keeps detector, bandgap, low clock on.
// - High select 0: codes 000/001 low clock, 010..111 divide 64..2.
// - High select 1 uses undivided high-speed clock.
// - Moving to low clock stops high oscillator and all its dividers.
// - Read-only low oscillator ready flag rises 1 to 2 cycles later.
// - Read-only high ready flag, low in sleep/idle_clock_stopped_mode, rises after 15-16; code raises it on the fifteenth high tick.
// - Slow switch completes only once low oscillator is ready.
// - Low-voltage reset sets cause flag; only software write 0 clears (code also clears it on rst_n_in).
// - Bad threshold register value sets flag and resets; software clears.
// - Bad watchdog control sets flag and resets; software write 0 clears.
// - Halt mode uses idle bits; run mode uses clock select only.
// - Any halt sets power-down flag, clears timeout, clears watchdog.
// - Port falling edge, interrupt or watchdog overflow wakes device.
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scpm_consts.vh"

module scpm_clock_power_ctrl (
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    input  wire        halt_exec_in,
    input  wire        voltage_detect_enable_in,
    input  wire        low_voltage_reset_event_in,
    input  wire        voltage_threshold_bad_in,
    input  wire        watchdog_ctrl_bad_in,
    input  wire        port_wake_fall_in,
    input  wire        sys_irq_wake_in,
    input  wire        wdt_overflow_in,
    input  wire        high_osc_tick_in,
    input  wire        low_osc_tick_in,
    output reg         cpu_run_out,
    output reg         sys_clk_en_out,
    output reg         time_base_clk_en_out,
    output reg         low_osc_en_out,
    output reg         high_osc_en_out,
    output reg  [6:0]  high_div_tap_en_out,
    output reg         lvd_bandgap_keep_out,
    output reg         power_down_flag_out,
    output reg         wdt_timeout_clr_out,
    output reg         wdt_clear_out,
    output reg         wdt_reset_req_out,
    output reg         soft_reset_req_out,
    output reg  [2:0]  op_mode_out,
    output reg         irq_out
);

    reg  [2:0] clock_select_field_r;
    reg        idle_select_r;
    reg        high_speed_select_r;
    reg        idle_system_clock_keep_r;
    reg        low_voltage_reset_cause_r;
    reg        voltage_threshold_reg_reset_flag_r;
    reg        watchdog_ctrl_reset_flag_r;
    reg        low_osc_ready_flag_r;
    reg        high_osc_ready_flag_r;
    reg  [1:0] low_cnt_r;
    reg  [4:0] high_cnt_r;
    reg  [2:0] mode_r;
    reg        halted_r;
    reg  [3:0] irq_status_r;
    reg  [3:0] irq_mask_r;
    reg  [5:0] div_cnt_r;
    reg        high_rdy_d_r;

    wire       bus_req   = avs_read_in | avs_write_in;
    wire [1:0] reg_idx   = avs_address_in[3:2];
    wire       wr_lo     = avs_write_in & avs_byteenable_in[0] &
                           ~avs_waitrequest_out;
    wire       rd_take   = avs_read_in & ~avs_waitrequest_out;
    wire       low_code  = (clock_select_field_r == `SCPM_CKS_LOW0) ||
                           (clock_select_field_r == `SCPM_CKS_LOW1);
    // Run mode follows only the select fields
    wire       want_slow = ~high_speed_select_r & low_code;
    wire       wake      = port_wake_fall_in | sys_irq_wake_in |
                           wdt_overflow_in;
    // A held halt level must not replay the entry side effects
    wire       halt_go   = halt_exec_in & ~halted_r;
    wire       rst_cause = low_voltage_reset_event_in |
                           voltage_threshold_bad_in | watchdog_ctrl_bad_in;

    reg  [2:0] mode_nxt;
    reg  [7:0] cms_rd;
    reg  [7:0] icr_rd;
    reg  [6:0] tap_nxt;

    // Halt target decided from the idle bits sampled this cycle
    always @* begin
        mode_nxt = mode_r;
        if (halted_r) begin
            if (wake) begin
                // Wake clears the low ready flag, so slow must wait for it
                mode_nxt = `SCPM_MODE_NORMAL;
            end
        end else if (halt_exec_in) begin
            if (!idle_select_r) begin
                mode_nxt = `SCPM_MODE_SLEEP;
            end else if (!idle_system_clock_keep_r) begin
                mode_nxt = `SCPM_MODE_IDLE_CLOCK_STOPPED_MODE;
            end else begin
                mode_nxt = `SCPM_MODE_IDLE_CLOCK_RUNNING_MODE;
            end
        end else if (want_slow && low_osc_ready_flag_r) begin
            mode_nxt = `SCPM_MODE_SLOW;
        end else if (!want_slow) begin
            mode_nxt = `SCPM_MODE_NORMAL;
        end
    end

    always @* begin
        cms_rd = 8'h00;
        cms_rd[`SCPM_CMS_CKS_HI:`SCPM_CMS_CKS_LO] = clock_select_field_r;
        cms_rd[`SCPM_CMS_LTO]   = low_osc_ready_flag_r;
        cms_rd[`SCPM_CMS_HTO]   = high_osc_ready_flag_r;
        cms_rd[`SCPM_CMS_IDLE_SELECT] = idle_select_r;
        cms_rd[`SCPM_CMS_HSEL]  = high_speed_select_r;
    end

    // Unimplemented bits read as zero
    always @* begin
        icr_rd = 8'h00;
        icr_rd[`SCPM_ICR_IDLE_SYSTEM_CLOCK_KEEP] = idle_system_clock_keep_r;
        icr_rd[`SCPM_ICR_LOW_VOLTAGE_RESET_CAUSE]   = low_voltage_reset_cause_r;
        icr_rd[`SCPM_ICR_LRF]    = voltage_threshold_reg_reset_flag_r;
        icr_rd[`SCPM_ICR_WRF]    = watchdog_ctrl_reset_flag_r;
    end

    // Bus slave: one wait cycle, then the access completes
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
            if (bus_req && avs_waitrequest_out) begin
                case (reg_idx)
                    `SCPM_IDX_CLK_MODE:   avs_readdata_out <= {24'h0, cms_rd};
                    `SCPM_IDX_IDLE_CTRL:  avs_readdata_out <= {24'h0, icr_rd};
                    `SCPM_IDX_IRQ_STATUS: avs_readdata_out <=
                                              {28'h0, irq_status_r};
                    `SCPM_IDX_IRQ_MASK:   avs_readdata_out <=
                                              {28'h0, irq_mask_r};
                    default:              avs_readdata_out <= 32'h0;
                endcase
            end
        end
    end

    // Software fields and reset-cause flags; set beats software clear
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            clock_select_field_r     <= 3'b110;
            idle_select_r            <= 1'b1;
            high_speed_select_r      <= 1'b0;
            idle_system_clock_keep_r <= 1'b0;
            low_voltage_reset_cause_r          <= 1'b0;
            voltage_threshold_reg_reset_flag_r <= 1'b0;
            watchdog_ctrl_reset_flag_r         <= 1'b0;
            irq_mask_r               <= 4'h0;
        end else begin
            if (wr_lo && reg_idx == `SCPM_IDX_CLK_MODE) begin
                clock_select_field_r <= avs_writedata_in[7:5];
                idle_select_r        <= avs_writedata_in[`SCPM_CMS_IDLE_SELECT];
                high_speed_select_r  <= avs_writedata_in[`SCPM_CMS_HSEL];
            end
            if (wr_lo && reg_idx == `SCPM_IDX_IDLE_CTRL) begin
                idle_system_clock_keep_r <= avs_writedata_in[7];
                // Flags can only be written to zero
                if (!avs_writedata_in[`SCPM_ICR_LOW_VOLTAGE_RESET_CAUSE]) begin
                    low_voltage_reset_cause_r <= 1'b0;
                end
                if (!avs_writedata_in[`SCPM_ICR_LRF]) begin
                    voltage_threshold_reg_reset_flag_r <= 1'b0;
                end
                if (!avs_writedata_in[`SCPM_ICR_WRF]) begin
                    watchdog_ctrl_reset_flag_r <= 1'b0;
                end
            end
            if (wr_lo && reg_idx == `SCPM_IDX_IRQ_MASK) begin
                irq_mask_r <= avs_writedata_in[3:0];
            end
            // Set is written last so an event beats a same-cycle clear
            if (low_voltage_reset_event_in) begin
                low_voltage_reset_cause_r <= 1'b1;
            end
            if (voltage_threshold_bad_in) begin
                voltage_threshold_reg_reset_flag_r <= 1'b1;
            end
            if (watchdog_ctrl_bad_in) begin
                watchdog_ctrl_reset_flag_r <= 1'b1;
            end
        end
    end

    // Mode state and halt side effects
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mode_r              <= `SCPM_MODE_NORMAL;
            halted_r            <= 1'b0;
            power_down_flag_out <= 1'b0;
            wdt_timeout_clr_out <= 1'b0;
            wdt_clear_out       <= 1'b0;
            wdt_reset_req_out   <= 1'b0;
            soft_reset_req_out  <= 1'b0;
        end else begin
            mode_r              <= mode_nxt;
            wdt_timeout_clr_out <= halt_go;
            wdt_clear_out       <= halt_go;
            wdt_reset_req_out   <= halted_r & wdt_overflow_in;
            soft_reset_req_out  <= voltage_threshold_bad_in |
                                   watchdog_ctrl_bad_in;
            if (halt_go) begin
                halted_r            <= 1'b1;
                power_down_flag_out <= 1'b1;
            end else if (halted_r && wake) begin
                halted_r <= 1'b0;
            end
        end
    end

    // Oscillator ready flags count ticks of their own oscillator
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            low_osc_ready_flag_r  <= 1'b0;
            high_osc_ready_flag_r <= 1'b0;
            low_cnt_r             <= 2'd0;
            high_cnt_r            <= 5'd0;
        end else begin
            if (halted_r && wake) begin
                low_osc_ready_flag_r <= 1'b0;
                low_cnt_r            <= 2'd0;
            end else if (!low_osc_ready_flag_r && low_osc_tick_in) begin
                // Ready on the second low clock tick
                if (low_cnt_r == `SCPM_LOW_SETTLE - 2'd1) begin
                    low_osc_ready_flag_r <= 1'b1;
                end
                low_cnt_r <= low_cnt_r + 2'd1;
            end
            if (!high_osc_en_out || (halted_r && wake)) begin
                high_osc_ready_flag_r <= 1'b0;
                high_cnt_r            <= 5'd0;
            end else if (!high_osc_ready_flag_r && high_osc_tick_in) begin
                // Flag rises on the fifteenth tick after enable
                if (high_cnt_r == `SCPM_HIGH_SETTLE - 5'd2) begin
                    high_osc_ready_flag_r <= 1'b1;
                end
                high_cnt_r <= high_cnt_r + 5'd1;
            end
        end
    end

    // High clock divider chain, running only while the oscillator runs
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            div_cnt_r <= 6'd0;
        end else if (!high_osc_en_out) begin
            div_cnt_r <= 6'd0;
        end else if (high_osc_tick_in) begin
            div_cnt_r <= div_cnt_r + 6'd1;
        end
    end

    // Tap k is divide by 2**k; taps are enables, gating lives outside
    always @* begin
        tap_nxt = 7'h00;
        if (!high_osc_en_out) begin
            tap_nxt = 7'h00;
        end else if (high_speed_select_r) begin
            tap_nxt = 7'h01;
        end else begin
            case (clock_select_field_r)
                `SCPM_CKS_DIV64: tap_nxt = 7'h40;
                3'h3:            tap_nxt = 7'h20;
                3'h4:            tap_nxt = 7'h10;
                3'h5:            tap_nxt = 7'h08;
                3'h6:            tap_nxt = 7'h04;
                `SCPM_CKS_DIV2:  tap_nxt = 7'h02;
                default:         tap_nxt = 7'h00;
            endcase
        end
    end

    // Clock gating outputs from the mode
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cpu_run_out          <= 1'b0;
            sys_clk_en_out       <= 1'b0;
            time_base_clk_en_out <= 1'b0;
            low_osc_en_out       <= 1'b0;
            high_osc_en_out      <= 1'b0;
            high_div_tap_en_out  <= 7'h00;
            lvd_bandgap_keep_out <= 1'b0;
            op_mode_out          <= `SCPM_MODE_NORMAL;
        end else begin
            op_mode_out <= mode_nxt;
            cpu_run_out <= (mode_nxt == `SCPM_MODE_NORMAL) ||
                           (mode_nxt == `SCPM_MODE_SLOW);
            sys_clk_en_out <= (mode_nxt == `SCPM_MODE_NORMAL) ||
                              (mode_nxt == `SCPM_MODE_SLOW) ||
                              (mode_nxt == `SCPM_MODE_IDLE_CLOCK_RUNNING_MODE);
            time_base_clk_en_out <=
                mode_nxt != `SCPM_MODE_SLEEP;
            // Low clock never stops in any listed mode
            low_osc_en_out <= 1'b1;
            lvd_bandgap_keep_out <= voltage_detect_enable_in &
                (halted_r | halt_go);
            // High oscillator off in slow, sleep, idle_clock_stopped_mode and slow-idle_clock_running_mode
            high_osc_en_out <= (mode_nxt == `SCPM_MODE_NORMAL) ||
                ((mode_nxt == `SCPM_MODE_IDLE_CLOCK_RUNNING_MODE) && !want_slow) ||
                ((mode_nxt == `SCPM_MODE_SLOW) && !low_osc_ready_flag_r);
            high_div_tap_en_out <= tap_nxt;
        end
    end

    // Interrupt status: sticky, read clears, new event wins
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_status_r <= 4'h0;
            high_rdy_d_r <= 1'b0;
            irq_out      <= 1'b0;
        end else begin
            high_rdy_d_r <= high_osc_ready_flag_r;
            irq_status_r <=
                ((rd_take && reg_idx == `SCPM_IDX_IRQ_STATUS) ?
                    4'h0 : irq_status_r) |
                {rst_cause, high_osc_ready_flag_r & ~high_rdy_d_r,
                 halted_r & wake, halt_go};
            irq_out <= |(irq_status_r & irq_mask_r);
        end
    end

endmodule
`default_nettype wire

// file: scpm_consts.vh
// Register offsets, field positions, reset values and timing counts
`ifndef SCPM_CONSTS_VH
`define SCPM_CONSTS_VH

// Word offsets on the register bus (byte address = 4 * index)
`define SCPM_IDX_CLK_MODE     2'd0
`define SCPM_IDX_IDLE_CTRL    2'd1
`define SCPM_IDX_IRQ_STATUS   2'd2
`define SCPM_IDX_IRQ_MASK     2'd3

// clock_mode_select fields
`define SCPM_CMS_CKS_HI       7
`define SCPM_CMS_CKS_LO       5
`define SCPM_CMS_LTO          3
`define SCPM_CMS_HTO          2
`define SCPM_CMS_IDLE_SELECT        1
`define SCPM_CMS_HSEL         0
`define SCPM_CMS_RESET        8'hc2

// idle_clock_and_reset_cause fields
`define SCPM_ICR_IDLE_SYSTEM_CLOCK_KEEP       7
`define SCPM_ICR_LOW_VOLTAGE_RESET_CAUSE         2
`define SCPM_ICR_LRF          1
`define SCPM_ICR_WRF          0
`define SCPM_ICR_RESET        8'h00

// Interrupt status bits
`define SCPM_IRQ_HALT         0
`define SCPM_IRQ_WAKE         1
`define SCPM_IRQ_HRDY         2
`define SCPM_IRQ_RSTCAUSE     3

// Oscillator settle counts, in cycles of the running oscillator
`define SCPM_LOW_SETTLE       2'd2
`define SCPM_HIGH_SETTLE      5'd16

// Clock select codes
`define SCPM_CKS_LOW0         3'b000
`define SCPM_CKS_LOW1         3'b001
`define SCPM_CKS_DIV64        3'b010
`define SCPM_CKS_DIV2         3'b111

// Operating modes
`define SCPM_MODE_NORMAL      3'd0
`define SCPM_MODE_SLOW        3'd1
`define SCPM_MODE_SLEEP       3'd2
`define SCPM_MODE_IDLE_CLOCK_STOPPED_MODE       3'd3
`define SCPM_MODE_IDLE_CLOCK_RUNNING_MODE       3'd4

`endif

// file: scpm_cpc_assertions.sv
// Concurrent checks on the clock and power mode controller ports
`timescale 1ns/10ps
`default_nettype none
`include "scpm_consts.vh"
module scpm_cpc_assertions (
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out,
    input wire logic       halt_exec_in,
    input wire logic       voltage_detect_enable_in,
    input wire logic       voltage_threshold_bad_in,
    input wire logic       watchdog_ctrl_bad_in,
    input wire logic       port_wake_fall_in,
    input wire logic       sys_irq_wake_in,
    input wire logic       wdt_overflow_in,
    input wire logic       cpu_run_out,
    input wire logic       sys_clk_en_out,
    input wire logic       time_base_clk_en_out,
    input wire logic       low_osc_en_out,
    input wire logic       high_osc_en_out,
    input wire logic [6:0] high_div_tap_en_out,
    input wire logic       lvd_bandgap_keep_out,
    input wire logic       power_down_flag_out,
    input wire logic       wdt_timeout_clr_out,
    input wire logic       wdt_clear_out,
    input wire logic       wdt_reset_req_out,
    input wire logic       soft_reset_req_out,
    input wire logic [2:0] op_mode_out
);
    logic halted;
    logic wake;
    assign halted = op_mode_out >= `SCPM_MODE_SLEEP;
    assign wake = port_wake_fall_in | sys_irq_wake_in | wdt_overflow_in;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Exactly one wait state per access
    AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) &&
        avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("wait state count wrong");
    AST_SLEEP_CLKS: assert property (op_mode_out == `SCPM_MODE_SLEEP |-> !cpu_run_out && !sys_clk_en_out && !time_base_clk_en_out && low_osc_en_out)
        else $error("sleep clock gating wrong");
    AST_IDLE_CLOCK_STOPPED_MODE_CLKS: assert property (op_mode_out == `SCPM_MODE_IDLE_CLOCK_STOPPED_MODE |-> !cpu_run_out && !sys_clk_en_out && !high_osc_en_out && time_base_clk_en_out && low_osc_en_out)
        else $error("idle_clock_stopped_mode clock gating wrong");
    AST_IDLE_CLOCK_RUNNING_MODE_CLKS: assert property (op_mode_out == `SCPM_MODE_IDLE_CLOCK_RUNNING_MODE |-> !cpu_run_out && sys_clk_en_out && time_base_clk_en_out && low_osc_en_out)
        else $error("idle_clock_running_mode clock gating wrong");
    AST_LVD_KEEP: assert property (halted && $past(halted) && voltage_detect_enable_in && $past(voltage_detect_enable_in) |-> lvd_bandgap_keep_out && low_osc_en_out)
        else $error("detector not kept on in halt");
    AST_SLOW_HIGH_OFF: assert property (op_mode_out == `SCPM_MODE_SLOW && $past(op_mode_out, 2) == `SCPM_MODE_SLOW |-> !high_osc_en_out && high_div_tap_en_out == 7'h00)
        else $error("high oscillator runs in slow mode");
    AST_NORMAL_RUN: assert property (op_mode_out == `SCPM_MODE_NORMAL && $past(op_mode_out) == `SCPM_MODE_NORMAL && $past(rst_n_in) |-> cpu_run_out && sys_clk_en_out && high_osc_en_out)
        else $error("normal mode clocks off");
    AST_HALT_ENTRY: assert property (halt_exec_in && !halted |=> ##[0:1] halted && power_down_flag_out && wdt_clear_out && wdt_timeout_clr_out)
        else $error("halt entry side effects missing");
    AST_PDF_STICKY: assert property (power_down_flag_out |=> power_down_flag_out)
        else $error("power down flag dropped");
    AST_WAKE: assert property (halted && wake && !halt_exec_in |=> ##[0:1] !halted)
        else $error("no wake from halt");
    AST_WDT_RESET: assert property (halted && wdt_overflow_in |=> ##[0:1] wdt_reset_req_out)
        else $error("no watchdog reset on overflow wake");
    AST_SOFT_RESET: assert property (watchdog_ctrl_bad_in || voltage_threshold_bad_in |=> ##[0:1] soft_reset_req_out)
        else $error("no reset on bad control value");
endmodule
`default_nettype wire

// file: tb_scpm_clock_power_ctrl.sv
// Self-checking bench for the clock and power mode controller
`timescale 1ns/10ps
`default_nettype none
`include "scpm_consts.vh"
module tb_scpm_clock_power_ctrl;
    logic        clk = 0, rst_n = 0, rd = 0, wr = 0, halt = 0, vde = 0;
    logic        lvr = 0, thr = 0, wdc = 0, pw = 0, iw = 0, wo = 0;
    logic        ht = 0, lt = 0;
    logic [3:0]  addr = 0, be = 4'h1;
    logic [31:0] wd = 0;
    wire  [31:0] rdata;
    wire         wreq, cpu, sce, tbe, loe, hoe, lvdk, power_down_flag, irq;
    wire  [6:0]  taps;
    wire  [2:0]  mode;
    logic [7:0]  eq[$], mq[$];
    logic [2:0]  xm[3] = '{`SCPM_MODE_SLEEP, `SCPM_MODE_IDLE_CLOCK_STOPPED_MODE, `SCPM_MODE_IDLE_CLOCK_RUNNING_MODE};
    integer      n_errors = 0, total_checks = 0, seed = 20329, k, j;
    always #5 clk = ~clk;
    scpm_clock_power_ctrl i_dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .halt_exec_in(halt),
        .voltage_detect_enable_in(vde), .low_voltage_reset_event_in(lvr),
        .voltage_threshold_bad_in(thr), .watchdog_ctrl_bad_in(wdc),
        .port_wake_fall_in(pw), .sys_irq_wake_in(iw), .wdt_overflow_in(wo),
        .high_osc_tick_in(ht), .low_osc_tick_in(lt), .cpu_run_out(cpu),
        .sys_clk_en_out(sce), .time_base_clk_en_out(tbe),
        .low_osc_en_out(loe), .high_osc_en_out(hoe),
        .high_div_tap_en_out(taps), .lvd_bandgap_keep_out(lvdk),
        .power_down_flag_out(power_down_flag), .wdt_timeout_clr_out(),
        .wdt_clear_out(), .wdt_reset_req_out(), .soft_reset_req_out(),
        .op_mode_out(mode), .irq_out(irq));
    task complete_run;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        begin
            total_checks++;
            if (s !== e) begin
                n_errors++;
                $display("ERROR %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Read queues expected byte and mask; monitor compares
    task bus(input [1:0] idx, input bit w, input [7:0] d, input [7:0] m);
        integer i;
        begin
            addr <= {idx, 2'b00};
            rd <= !w;
            wr <= w;
            wd <= {24'h0, d};
            if (!w) begin
                eq.push_back(d);
                mq.push_back(m);
            end
            i = 0;
            do begin
                @(posedge clk);
                i++;
            end while (wreq !== 1'b0 && i < 20);
            if (i >= 20) begin
                n_errors++;
                complete_run;
            end
            rd <= 0;
            wr <= 0;
            @(posedge clk);
        end
    endtask
    // Oscillator ticks arrive at random, as a real RC source would drift
    always @(posedge clk) begin
        ht <= $random(seed);
        lt <= ($random(seed) & 3) == 0;
    end
    always @(posedge clk)
        if (rd && wreq === 1'b0) begin
            if (eq.size() == 0) chk("read queue", 8'h01, 8'h00);
            else begin
                chk("readdata", rdata[7:0] & mq[0], eq[0] & mq[0]);
                void'(eq.pop_front());
                void'(mq.pop_front());
            end
        end
    initial begin
        cyc(20000);
        n_errors++;
        complete_run;
    end
    initial begin
        cyc(5);
        rst_n <= 1;
        cyc(80);
        bus(0, 0, 8'hce, 8'hff);
        bus(1, 0, 8'h00, 8'hff);
        be <= 4'h0;
        bus(1, 1, 8'h80, 0);
        bus(1, 0, 8'h00, 8'hff);
        be <= 4'h1;
        for (k = 2; k < 8; k++) begin
            bus(0, 1, {k[2:0], 5'h00}, 0);
            cyc(2);
            chk("tap", {1'b0, taps}, 8'h1 << (8 - k));
        end
        bus(0, 1, 8'h01, 0);
        cyc(2);
        chk("tap", {1'b0, taps}, 8'h01);
        bus(0, 1, 8'h20, 0);
        cyc(4);
        chk("mode", {5'h0, mode}, {5'h0, `SCPM_MODE_SLOW});
        chk("high osc", {7'h0, hoe}, 8'h00);
        bus(0, 1, 8'he1, 0);
        cyc(80);
        for (j = 0; j < 3; j++) begin
            bus(1, 1, {j == 2, 7'h0}, 0);
            bus(0, 1, {6'h38, j > 0, 1'b1}, 0);
            vde <= j == 1;
            halt <= 1;
            cyc(1);
            halt <= 0;
            cyc(3);
            chk("mode", {5'h0, mode}, {5'h0, xm[j]});
            chk("pdf", {7'h0, power_down_flag}, 8'h01);
            chk("lvd", {7'h0, lvdk & loe}, {7'h0, j == 1});
            chk("run", {6'h0, cpu, sce}, {7'h0, j == 2});
            chk("tbase", {7'h0, tbe}, {7'h0, j != 0});
            bus(0, 1, {6'h38, j == 0, 1'b1}, 0);
            chk("mode", {5'h0, mode}, {5'h0, xm[j]});
            pw <= j == 0;
            iw <= j == 1;
            wo <= j == 2;
            cyc(1);
            {pw, iw, wo, vde} <= 0;
            cyc(3);
            chk("mode", {5'h0, mode}, {5'h0, `SCPM_MODE_NORMAL});
            cyc(80);
        end
        bus(2, 0, 0, 0);
        bus(3, 1, 8'h08, 0);
        chk("irq", {7'h0, irq}, 8'h00);
        {lvr, thr, wdc} <= 3'h7;
        cyc(1);
        {lvr, thr, wdc} <= 0;
        cyc(3);
        chk("irq", {7'h0, irq}, 8'h01);
        bus(1, 0, 8'h07, 8'h07);
        bus(1, 1, 8'h07, 0);
        bus(1, 0, 8'h07, 8'h07);
        bus(1, 1, 8'h00, 0);
        bus(1, 0, 8'h00, 8'hff);
        bus(2, 0, 8'h08, 8'h08);
        cyc(2);
        chk("irq", {7'h0, irq}, 8'h00);
        bus(3, 1, 8'h00, 0);
        wdc <= 1;
        cyc(1);
        wdc <= 0;
        cyc(3);
        chk("irq", {7'h0, irq}, 8'h00);
        complete_run;
    end
endmodule
bind scpm_clock_power_ctrl scpm_cpc_assertions i_chk (
    .sys_clk_in, .rst_n_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .halt_exec_in, .voltage_detect_enable_in,
    .voltage_threshold_bad_in, .watchdog_ctrl_bad_in, .port_wake_fall_in,
    .sys_irq_wake_in, .wdt_overflow_in, .cpu_run_out, .sys_clk_en_out,
    .time_base_clk_en_out, .low_osc_en_out, .high_osc_en_out,
    .high_div_tap_en_out, .lvd_bandgap_keep_out, .power_down_flag_out,
    .wdt_timeout_clr_out, .wdt_clear_out, .wdt_reset_req_out,
    .soft_reset_req_out, .op_mode_out);
`default_nettype wire
